/* File: verilog/tca_pkg.sv */
// Shared types and constants for the Type-C attach and SuperSpeed PHY enable logic.
package tca_pkg;

    // Number of connect-detect inputs used by the external multiplexer configuration.
    localparam int unsigned TCA_DETECT_WIDTH = 3;

    // Index of the connect-detect input that internal mode 1 uses.
    localparam int unsigned TCA_DETECT_FIRST = 0;

    // Total width of the pin bundle that is synchronised.
    localparam int unsigned TCA_PIN_WIDTH = 9;

    // Value of each synchroniser stage after reset.
    localparam logic [TCA_PIN_WIDTH-1:0] TCA_SYNC_RESET = 9'h000;

    // Attach and orientation pins as they arrive from the port controller and the straps.
    typedef struct packed {
        logic external_mux_config;
        logic input_polarity_select;
        logic internal_mux_mode_select;
        logic [TCA_DETECT_WIDTH-1:0] typec_connect_detect;
        logic cable_orientation_in;
        logic orient_sel_a_in;
        logic orient_sel_b_in;
    } tca_pins_type;

    // Controls driven towards the SuperSpeed PHYs, plus status of the decoded attach.
    typedef struct packed {
        logic ss_phy_clock_enable;
        logic ss_phy_enable_a;
        logic ss_phy_enable_b;
        logic attach_valid;
        logic orientation_flipped;
    } tca_phy_ctl_type;

    // Value of the PHY control outputs after reset: everything off.
    localparam tca_phy_ctl_type TCA_PHY_CTL_RESET = 5'h00;

    // Configuration selected by the straps.
    typedef enum {
        TCA_CFG_EXTERNAL,
        TCA_CFG_MODE1,
        TCA_CFG_MODE2
    } tca_config_type;

    // Which PHY path is powered.
    typedef enum {
        TCA_OFF,
        TCA_EXT_ON,
        TCA_LANE_A,
        TCA_LANE_B
    } tca_state_type;

endpackage : tca_pkg

/* File: verilog/tca_sync2.sv */
// Two-stage synchroniser for a bundle of independent level inputs.
`timescale 1ns/1ps

module tca_sync2 #(
    parameter int unsigned WIDTH = tca_pkg::TCA_PIN_WIDTH
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // Each bit gets its own pair of flops; the first stage feeds only the second.
    genvar bit_index;
    generate
        for (bit_index = 0; bit_index < WIDTH; bit_index++) begin : g_bit
            logic meta;
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    meta <= tca_pkg::TCA_SYNC_RESET[bit_index];
                    sync_out[bit_index] <= tca_pkg::TCA_SYNC_RESET[bit_index];
                end else begin
                    meta <= async_in[bit_index];
                    sync_out[bit_index] <= meta;
                end
            end
        end
    endgenerate

endmodule : tca_sync2

/* File: verilog/tca_attach_phy_enable.sv */
// Type-C attach decode that gates SuperSpeed PHY clocking or enables the PHY for the detected orientation.
// Contract
// - With the external multiplexer, PHY clocking runs only while the connect-detect inputs show an attach.
// - One polarity-select input inverts the sense of every attach and orientation input together.
// - A low (or undriven, pulled low) mode-select input selects internal multiplexer mode 1.
// - Mode 1 takes attach from the first connect-detect input and orientation from the orientation input.
// - In both internal modes only the PHY matching the attach and orientation is on; the other stays off.
// - A high mode-select input selects internal multiplexer mode 2.
// - Mode 2 takes attach and orientation from the two orientation-select inputs A and B.
`timescale 1ns/1ps

module tca_attach_phy_enable (
    input wire logic clock,
    input wire logic resetn,
    input wire tca_pkg::tca_pins_type pins,
    output tca_pkg::tca_phy_ctl_type phy_ctl
);

    tca_pkg::tca_pins_type synced;
    logic [tca_pkg::TCA_DETECT_WIDTH-1:0] detect_active;
    logic orient_active;
    logic sel_a_active;
    logic sel_b_active;
    tca_pkg::tca_config_type config_mode;
    tca_pkg::tca_state_type state;
    tca_pkg::tca_state_type next_state;
    tca_pkg::tca_phy_ctl_type next_phy_ctl;

    // Pins come from another chip and from straps, so every one passes the synchroniser first.
    tca_sync2 #(
        .WIDTH(tca_pkg::TCA_PIN_WIDTH)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in(pins),
        .sync_out(synced)
    );

    // A single polarity bit flips all attach inputs together, so the decode never sees mixed senses.
    always_comb begin
        detect_active = synced.typec_connect_detect
            ^ {tca_pkg::TCA_DETECT_WIDTH{synced.input_polarity_select}};
        orient_active = synced.cable_orientation_in ^ synced.input_polarity_select;
        sel_a_active = synced.orient_sel_a_in ^ synced.input_polarity_select;
        sel_b_active = synced.orient_sel_b_in ^ synced.input_polarity_select;
    end

    // The external multiplexer strap takes priority; otherwise the mode-select level picks the internal mode.
    always_comb begin
        if (synced.external_mux_config) begin
            config_mode = tca_pkg::TCA_CFG_EXTERNAL;
        end else if (synced.internal_mux_mode_select) begin
            config_mode = tca_pkg::TCA_CFG_MODE2;
        end else begin
            config_mode = tca_pkg::TCA_CFG_MODE1;
        end
    end

    // Decode the attach into the PHY path to power; the inputs are levels, so the path follows them directly.
    always_comb begin
        case (config_mode)
            tca_pkg::TCA_CFG_EXTERNAL: begin
                // Any asserted connect-detect input counts as an attach.
                next_state = (|detect_active) ? tca_pkg::TCA_EXT_ON : tca_pkg::TCA_OFF;
            end
            tca_pkg::TCA_CFG_MODE1: begin
                if (!detect_active[tca_pkg::TCA_DETECT_FIRST]) begin
                    next_state = tca_pkg::TCA_OFF;
                end else if (orient_active) begin
                    next_state = tca_pkg::TCA_LANE_B;
                end else begin
                    next_state = tca_pkg::TCA_LANE_A;
                end
            end
            tca_pkg::TCA_CFG_MODE2: begin
                // Both selects at once gives no usable orientation, so both PHYs stay off.
                if (sel_a_active && !sel_b_active) begin
                    next_state = tca_pkg::TCA_LANE_A;
                end else if (sel_b_active && !sel_a_active) begin
                    next_state = tca_pkg::TCA_LANE_B;
                end else begin
                    next_state = tca_pkg::TCA_OFF;
                end
            end
            default: begin
                next_state = tca_pkg::TCA_OFF;
            end
        endcase
    end

    // Map each path to the PHY controls; at most one PHY is ever enabled.
    always_comb begin
        next_phy_ctl = tca_pkg::TCA_PHY_CTL_RESET;
        case (next_state)
            tca_pkg::TCA_EXT_ON: begin
                next_phy_ctl.ss_phy_clock_enable = 1'h1;
                next_phy_ctl.ss_phy_enable_a = 1'h1;
                next_phy_ctl.attach_valid = 1'h1;
            end
            tca_pkg::TCA_LANE_A: begin
                next_phy_ctl.ss_phy_clock_enable = 1'h1;
                next_phy_ctl.ss_phy_enable_a = 1'h1;
                next_phy_ctl.attach_valid = 1'h1;
            end
            tca_pkg::TCA_LANE_B: begin
                next_phy_ctl.ss_phy_clock_enable = 1'h1;
                next_phy_ctl.ss_phy_enable_b = 1'h1;
                next_phy_ctl.attach_valid = 1'h1;
                next_phy_ctl.orientation_flipped = 1'h1;
            end
            tca_pkg::TCA_OFF: begin
                next_phy_ctl = tca_pkg::TCA_PHY_CTL_RESET;
            end
            default: begin
                next_phy_ctl = tca_pkg::TCA_PHY_CTL_RESET;
            end
        endcase
    end

    // Path state register.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= tca_pkg::TCA_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Output register, so the PHY controls never glitch while the decode settles.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phy_ctl <= tca_pkg::TCA_PHY_CTL_RESET;
        end else begin
            phy_ctl <= next_phy_ctl;
        end
    end

    // Checks on the decode, all in the core clock domain.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // The synchronised view and the pins agree once the pins have held still long enough.
    // Reset must be off at the first of those edges too, since the synchroniser ignores pins while it is held.
    sequence pins_held_s;
        ($past(resetn) && $stable(pins)) [*3];
    endsequence

    sequence ext_attach_s;
        config_mode == tca_pkg::TCA_CFG_EXTERNAL && (|detect_active);
    endsequence

    sequence mode1_attach_s;
        config_mode == tca_pkg::TCA_CFG_MODE1 && detect_active[tca_pkg::TCA_DETECT_FIRST];
    endsequence

    ext_clock_on_a: assert property (ext_attach_s |=> phy_ctl.ss_phy_clock_enable && phy_ctl.attach_valid)
        else $error("External mux attach did not enable PHY clocking.");

    ext_clock_gated_a: assert property (config_mode == tca_pkg::TCA_CFG_EXTERNAL && !(|detect_active)
        |=> !phy_ctl.ss_phy_clock_enable && !phy_ctl.ss_phy_enable_a && !phy_ctl.ss_phy_enable_b)
        else $error("PHY clocking left on with no external attach.");

    pin_polarity_a: assert property (pins_held_s ##0 (pins.external_mux_config
        && pins.typec_connect_detect == {tca_pkg::TCA_DETECT_WIDTH{pins.input_polarity_select}})
        |-> !phy_ctl.ss_phy_clock_enable)
        else $error("Inactive connect-detect level under the selected polarity enabled clocking.");

    pin_latency_a: assert property (pins_held_s ##0 (pins.external_mux_config
        && pins.typec_connect_detect[0] != pins.input_polarity_select)
        |-> phy_ctl.ss_phy_clock_enable)
        else $error("Held active connect-detect pin did not enable clocking within three cycles.");

    mode1_lane_a: assert property (mode1_attach_s ##0 !orient_active |=> phy_ctl.ss_phy_enable_a
        && !phy_ctl.ss_phy_enable_b && !phy_ctl.orientation_flipped)
        else $error("Mode 1 normal orientation did not enable only PHY A.");

    mode1_flip_a: assert property (mode1_attach_s ##0 orient_active |=> phy_ctl.ss_phy_enable_b
        && !phy_ctl.ss_phy_enable_a && phy_ctl.orientation_flipped)
        else $error("Mode 1 flipped orientation did not enable only PHY B.");

    mode1_detach_a: assert property (config_mode == tca_pkg::TCA_CFG_MODE1 && !detect_active[tca_pkg::TCA_DETECT_FIRST]
        |=> !phy_ctl.ss_phy_enable_a && !phy_ctl.ss_phy_enable_b)
        else $error("Mode 1 kept a PHY on without attach.");

    mode2_select_a: assert property (synced.internal_mux_mode_select && !synced.external_mux_config
        && sel_a_active != sel_b_active |=> phy_ctl.ss_phy_enable_a == $past(sel_a_active)
        && phy_ctl.ss_phy_enable_b == $past(sel_b_active))
        else $error("Mode 2 did not follow the orientation-select inputs.");

    mode2_no_attach_a: assert property (config_mode == tca_pkg::TCA_CFG_MODE2 && sel_a_active == sel_b_active
        |=> !phy_ctl.attach_valid && !phy_ctl.ss_phy_enable_a && !phy_ctl.ss_phy_enable_b)
        else $error("Mode 2 enabled a PHY without a single orientation select.");

    one_phy_only_a: assert property (!(phy_ctl.ss_phy_enable_a && phy_ctl.ss_phy_enable_b))
        else $error("Both SuperSpeed PHYs enabled at once.");

    clock_tracks_phy_a: assert property (phy_ctl.ss_phy_clock_enable == (phy_ctl.ss_phy_enable_a
        || phy_ctl.ss_phy_enable_b) && phy_ctl.attach_valid == phy_ctl.ss_phy_clock_enable)
        else $error("PHY clock enable disagrees with PHY enables.");

    // The external multiplexer has a single PHY behind it, so PHY B and the flip flag stay low there.
    ext_single_phy_a: assert property (config_mode == tca_pkg::TCA_CFG_EXTERNAL
        |=> !phy_ctl.ss_phy_enable_b && !phy_ctl.orientation_flipped)
        else $error("External mux configuration enabled PHY B or flagged a flip.");

    // Pin-level view of mode 1: held active connect-detect and orientation end on PHY B alone.
    pin_mode1_flip_a: assert property (pins_held_s ##0 (!pins.external_mux_config
        && !pins.internal_mux_mode_select
        && pins.typec_connect_detect[tca_pkg::TCA_DETECT_FIRST] != pins.input_polarity_select
        && pins.cable_orientation_in != pins.input_polarity_select)
        |-> phy_ctl.ss_phy_enable_b && !phy_ctl.ss_phy_enable_a)
        else $error("Held mode 1 flipped attach pins did not enable PHY B alone.");

    // Pin-level view of mode 2: equal raw selects mean no single orientation, whatever the polarity.
    pin_mode2_none_a: assert property (pins_held_s ##0 (!pins.external_mux_config
        && pins.internal_mux_mode_select && pins.orient_sel_a_in == pins.orient_sel_b_in)
        |-> !phy_ctl.attach_valid && !phy_ctl.ss_phy_clock_enable)
        else $error("Held equal mode 2 selects left a PHY path on.");

    // The path register and the output register load from one decode, so they must name the same path.
    path_state_a: assert property (phy_ctl.attach_valid == (state != tca_pkg::TCA_OFF)
        && phy_ctl.orientation_flipped == (state == tca_pkg::TCA_LANE_B))
        else $error("Path state and PHY controls disagree.");

endmodule : tca_attach_phy_enable

/* File: bench/tca_port_ctrl_model.sv */
// Behavioural model of the external Type-C port controller that drives the hub's attach pins.
`timescale 1ns/1ps

module tca_port_ctrl_model (
    input wire logic attach,
    input wire logic flipped,
    input wire logic [2:0] lines,
    input wire logic both_sel,
    input wire logic polarity,
    output logic [2:0] detect,
    output logic orientation,
    output logic sel_a,
    output logic sel_b
);
    // The controller alone watches the receptacle and reports what it sees on its pins.
    // Every level is inverted when the polarity strap asks for active-low signalling.
    assign detect = (attach ? lines : 3'h0) ^ {3{polarity}};
    assign orientation = flipped ^ polarity;
    // Both selects at once is a fault that only a bench scenario commands.
    assign sel_a = ((attach & ~flipped) | both_sel) ^ polarity;
    assign sel_b = ((attach & flipped) | both_sel) ^ polarity;
endmodule : tca_port_ctrl_model

/* File: bench/typec_attach_phy_enable_tb.sv */
// Self-checking testbench for the Type-C attach decode and SuperSpeed PHY enable logic.
`timescale 1ns/1ps

module typec_attach_phy_enable_tb;
    localparam tca_pkg::tca_phy_ctl_type PHY_OFF = 5'h00;
    localparam tca_pkg::tca_phy_ctl_type PHY_A = 5'h1a;
    localparam tca_pkg::tca_phy_ctl_type PHY_B = 5'h17;
    logic clock;
    logic resetn;
    logic ext_cfg;
    logic pol;
    logic mode_sel;
    logic attach;
    logic flipped;
    logic both_sel;
    logic [2:0] lines;
    logic [2:0] detect;
    logic orientation;
    logic sel_a;
    logic sel_b;
    tca_pkg::tca_pins_type pins;
    tca_pkg::tca_phy_ctl_type phy_ctl;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // Straps come from the bench, attach lines from the port controller model.
    assign pins = {ext_cfg, pol, mode_sel, detect, orientation, sel_a, sel_b};

    tca_port_ctrl_model partner (.attach(attach), .flipped(flipped), .lines(lines), .both_sel(both_sel),
        .polarity(pol), .detect(detect), .orientation(orientation), .sel_a(sel_a), .sel_b(sel_b));

    tca_attach_phy_enable DUT (.clock(clock), .resetn(resetn), .pins(pins), .phy_ctl(phy_ctl));

    // Free-running core clock, 100 ns period.
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    // A hang is cut short well beyond the roughly 145 cycles the tests need.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles >= 2000) begin
            n_errors++;
            $display("timeout after %0d cycles", cycles);
            conclude();
        end
    end

    task automatic check_ctl(input tca_pkg::tca_phy_ctl_type exp);
        n_compared++;
        if (phy_ctl !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: expected %h, got %h", $time, exp, phy_ctl);
        end
    endtask : check_ctl

    // Changes the controller's report and waits out the three-edge latency.
    task automatic apply(input logic a, input logic f, input logic [2:0] l, input logic b);
        @(negedge clock);
        attach = a;
        flipped = f;
        lines = l;
        both_sel = b;
        repeat (3) @(negedge clock);
    endtask : apply

    task automatic test_external(input logic p);
        @(negedge clock);
        // Mode select takes both levels across the two polarities; the external strap must override it.
        {ext_cfg, pol, mode_sel} = {1'h1, p, ~p};
        for (int i = 0; i < 3; i++) begin
            apply(1'h1, 1'h1, 3'h1 << i, 1'h0);
            check_ctl(PHY_A);
            apply(1'h0, 1'h0, 3'h7, 1'h0);
            check_ctl(PHY_OFF);
        end
        $display("external mux test done, polarity %0d", p);
    endtask : test_external

    task automatic test_mode1(input logic p);
        @(negedge clock);
        {ext_cfg, pol, mode_sel} = {1'h0, p, 1'h0};
        apply(1'h1, 1'h0, 3'h1, 1'h1);
        check_ctl(PHY_A);
        apply(1'h1, 1'h1, 3'h1, 1'h0);
        check_ctl(PHY_B);
        apply(1'h1, 1'h0, 3'h6, 1'h0);
        check_ctl(PHY_OFF);
        apply(1'h0, 1'h1, 3'h7, 1'h0);
        check_ctl(PHY_OFF);
        $display("mode 1 test done, polarity %0d", p);
    endtask : test_mode1

    task automatic test_mode2(input logic p);
        @(negedge clock);
        {ext_cfg, pol, mode_sel} = {1'h0, p, 1'h1};
        // Connect-detect lines are active here and must give way to the selects.
        apply(1'h1, 1'h0, 3'h7, 1'h0);
        check_ctl(PHY_A);
        apply(1'h1, 1'h1, 3'h0, 1'h0);
        check_ctl(PHY_B);
        apply(1'h0, 1'h0, 3'h7, 1'h1);
        check_ctl(PHY_OFF);
        apply(1'h0, 1'h0, 3'h7, 1'h0);
        check_ctl(PHY_OFF);
        $display("mode 2 test done, polarity %0d", p);
    endtask : test_mode2

    // An attach must not act before it has crossed both synchroniser stages.
    task automatic test_latency;
        @(negedge clock);
        {ext_cfg, pol, mode_sel} = 3'h0;
        apply(1'h0, 1'h0, 3'h0, 1'h0);
        attach = 1'h1;
        lines = 3'h1;
        repeat (2) @(negedge clock);
        check_ctl(PHY_OFF);
        @(negedge clock);
        check_ctl(PHY_A);
        resetn = 1'h0;
        @(negedge clock);
        check_ctl(PHY_OFF);
        resetn = 1'h1;
        // The pins already show an attach, yet nothing may act before both stages refill after reset.
        repeat (2) @(negedge clock);
        check_ctl(PHY_OFF);
        @(negedge clock);
        check_ctl(PHY_A);
        $display("latency and reset test done");
    endtask : test_latency

    task automatic conclude;
        $display("compared %0d, wrong %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Main sequence: reset, then every configuration under both polarities.
    initial begin
        resetn = 1'h0;
        {ext_cfg, pol, mode_sel} = 3'h0;
        {attach, flipped, both_sel, lines} = 6'h00;
        // Twelve rising edges pass under reset before it is released on a falling edge.
        repeat (12) @(posedge clock);
        @(negedge clock);
        check_ctl(PHY_OFF);
        resetn = 1'h1;
        for (int p = 0; p < 2; p++) begin
            test_external(p[0]);
            test_mode1(p[0]);
            test_mode2(p[0]);
        end
        test_latency();
        conclude();
    end
endmodule : typec_attach_phy_enable_tb
